// ### rtl/fhcc_top.v
// Head-control command block: seek, recalibrate, header read, interrupt query.
// Assumes one drive on the step lines and a data path that reports headers.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "fhcc_defs.vh"

// Summary of operation
// RULE1: Format writes single-density preamble: 40 FF, 6 00, FC, 26 FF, 6 00, FE, ID, 11 FF, 6 00, mark.
// RULE2: Software picks gap length per sector size and density.
// RULE3: Control commands move no data; only header-read, recal, seek interrupt.
// RULE4: Header-read captures cylinder, head, sector, size of first header read.
// RULE5: No header by second index pulse: cause 01, no-id flag set, end.
// RULE6: Recalibrate clears track count, steps outward while track zero low.
// RULE7: Track zero high during recalibrate sets positioning done and ends.
// RULE8: Still low after 79 steps: positioning done and head fault, end.
// RULE9: Busy only in command phase, not while stepping.
// RULE10: Seek steps inward if present below target, outward if above.
// RULE11: Seek spaces steps by step interval, recompares, ends when equal.
// RULE12: Positioning has no result phase; head bit of status zero reads 0.
// RULE13: Leaving power-down clears track count and held status.
// RULE14: Interrupt on result phase entry, positioning end, non-DMA byte request.
// RULE15: Interrupt query clears interrupt and returns status zero.
// RULE16: Cause: done 0/code 11 polling, 1/00 normal, 1/01 abnormal.
// RULE17: Without interrupt query the drive stays marked busy.
// RULE18: Software queries interrupt cause right after every positioning command.
// RULE19: Without implied seek software does seek, query, header-read, transfer.
// RULE20: After power-up software issues recalibrate.
// RULE21: Software services pending interrupts before power-down.
// RULE22: Step interval sets pulse spacing; first interval may be shorter.
// RULE23: Non-DMA transfers signal via transfer-request bit and interrupt.
// RULE24: With polling enabled, one interrupt follows reset.
// RULE25: Seek moves track count by one per step toward target.
module fhcc_top #(
  parameter STEP_UNIT_CYCLES = `FHCC_STEP_UNIT_US * `FHCC_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        track_zero_in,
  input  wire        index_pulse_in,
  output wire        step_pulse_out,
  output wire        step_sense_out,
  output wire        ctrl_irq_out,
  input  wire        id_valid_in,
  input  wire [7:0]  id_cyl_in,
  input  wire [7:0]  id_head_in,
  input  wire [7:0]  id_sect_in,
  input  wire [7:0]  id_size_in,
  input  wire        result_phase_in,
  input  wire        xfer_byte_req_in,
  output wire [7:0]  fmt_byte_out,
  output wire        fmt_valid_out,
  input  wire        fmt_ready_in
);

  localparam [3:0] P_IDLE  = 4'b0001;
  localparam [3:0] P_CHECK = 4'b0010;
  localparam [3:0] P_PULSE = 4'b0100;
  localparam [3:0] P_WAIT  = 4'b1000;
  localparam integer PULSE_N  = `FHCC_STEP_PULSE_CYC;
  localparam [23:0] PULSE_CYC = PULSE_N[23:0];

  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg         step_q;
  reg         dir_q;
  reg         irq_q;
  reg  [3:0]  srt_q;
  reg         non_dma_q;
  reg         poll_en_q;
  reg         poll_pend_q;
  reg         cmd_busy_q;
  reg         drive_busy_q;
  reg         hreq_q;
  reg         pd_q;
  reg         refused_q;
  reg  [7:0]  st0_q;
  reg  [7:0]  st0_rd_q;
  reg         noid_q;
  reg  [31:0] id_q;
  reg  [31:0] fmtid_q;
  reg         fmt_arm_q;
  reg         fmt_del_q;
  reg  [3:0]  pos_q;
  reg         recal_q;
  reg  [6:0]  steps_q;
  reg  [23:0] tmr_q;
  reg  [7:0]  pcn_q;
  reg  [7:0]  tgt_q;
  reg         rid_q;
  reg         idx_seen_q;
  reg  [1:0]  tz_sync_q;
  reg  [2:0]  idx_sync_q;
  reg  [31:0] rdata_d;
  reg         rerr_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [7:0] make_st0;
    input [1:0] cause;
    input       done;
    input       fault;
    begin
      // Head address and drive select stay 0: single drive, no head report
      make_st0 = {cause, done, fault, 1'b0, 1'b0, 2'b00};
    end
  endfunction

  function [23:0] step_wait;
    input [3:0] step_interval_setting;
    reg   [31:0] prod;
    begin
      prod      = (`FHCC_SRT_SPAN - {1'b0, step_interval_setting}) * STEP_UNIT_CYCLES;
      step_wait = prod[23:0];
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tz_sync_q  <= 2'b00;
      idx_sync_q <= 3'b000;
    end else begin
      tz_sync_q  <= {tz_sync_q[0], track_zero_in};
      idx_sync_q <= {idx_sync_q[1:0], index_pulse_in};
    end
  end

  wire tz_s     = tz_sync_q[1];
  wire idx_rise = idx_sync_q[1] & ~idx_sync_q[2];

  // ****************************************************************
  // APB slave: one wait state, write and read at the pready edge
  // ****************************************************************
  wire       apb_acc = psel & penable & pready_q;
  wire       wr      = apb_acc & pwrite;
  wire       cmd_wr  = wr && (paddr == `FHCC_ADDR_CMD);
  wire [3:0] op      = pwdata[`FHCC_CMD_OP_HI:0];
  wire       pos_idle = pos_q[0];

  wire op_pos   = cmd_wr && ((op == `FHCC_OP_SEEK) || (op == `FHCC_OP_RECAL));
  wire op_rid   = cmd_wr && (op == `FHCC_OP_READ_ID);
  wire op_sense = cmd_wr && (op == `FHCC_OP_SENSE) && !pd_q;
  wire op_fmt   = cmd_wr && (op == `FHCC_OP_FORMAT) && !pd_q;
  wire op_pd    = cmd_wr && (op == `FHCC_OP_PDOWN) && pos_idle && !rid_q;
  wire op_wake  = cmd_wr && (op == `FHCC_OP_WAKE) && pd_q;
  wire op_ack   = cmd_wr && (op == `FHCC_OP_XFER_ACK);
  // Drive left busy by an unanswered positioning command blocks the next one
  wire start_pos = op_pos && !drive_busy_q && !pd_q && !rid_q; // RULE17
  wire start_rid = op_rid && pos_idle && !rid_q && !pd_q;
  wire refuse    = (op_pos && !start_pos) || (op_rid && !start_rid);

  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    case (paddr)
      `FHCC_ADDR_CMD:   rdata_d = {24'h00_0000, 4'h0, 4'h0};
      `FHCC_ADDR_CFG:   rdata_d = {26'h000_0000, poll_en_q, non_dma_q, srt_q};
      `FHCC_ADDR_STAT:  rdata_d = {25'h000_0000, ~pos_idle, refused_q, pd_q, hreq_q,
                                   irq_q, drive_busy_q, cmd_busy_q};
      `FHCC_ADDR_ST0:   rdata_d = {24'h00_0000, st0_rd_q};
      `FHCC_ADDR_PCN:   rdata_d = {24'h00_0000, pcn_q};
      `FHCC_ADDR_ID:    rdata_d = id_q;
      `FHCC_ADDR_ST1:   rdata_d = {31'h0000_0000, noid_q};
      `FHCC_ADDR_FMTID: rdata_d = fmtid_q;
      default:          rerr_d  = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr_q <= rerr_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration and host-visible flags
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srt_q      <= `FHCC_SRT_RESET;
      non_dma_q  <= 1'b0;
      poll_en_q  <= `FHCC_POLL_RESET;
      fmtid_q    <= 32'h0000_0000;
      cmd_busy_q <= 1'b0;
      hreq_q     <= 1'b0;
      pd_q       <= 1'b0;
      refused_q  <= 1'b0;
      fmt_arm_q  <= 1'b0;
      fmt_del_q  <= 1'b0;
    end else begin
      if (wr && (paddr == `FHCC_ADDR_CFG)) begin
        srt_q     <= pwdata[`FHCC_CFG_SRT_HI:0];
        non_dma_q <= pwdata[`FHCC_CFG_NDMA_BIT];
        poll_en_q <= pwdata[`FHCC_CFG_POLL_BIT];
      end
      if (wr && (paddr == `FHCC_ADDR_FMTID))
        fmtid_q <= pwdata;
      // Busy covers the command phase only; stepping runs unbusy
      cmd_busy_q <= cmd_wr; // RULE9
      if (xfer_byte_req_in && non_dma_q)
        hreq_q <= 1'b1; // RULE23
      else if (op_ack)
        hreq_q <= 1'b0;
      if (op_pd)
        pd_q <= 1'b1;
      else if (op_wake)
        pd_q <= 1'b0;
      if (refuse)
        refused_q <= 1'b1;
      else if (cmd_wr)
        refused_q <= 1'b0;
      if (op_fmt) begin
        fmt_arm_q <= 1'b1;
        fmt_del_q <= pwdata[`FHCC_CMD_DEL_BIT];
      end else if (idx_rise) begin
        fmt_arm_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Positioning: seek and recalibrate stepper
  // ****************************************************************
  reg       pos_done;
  reg       pos_fault;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q     <= P_IDLE;
      recal_q   <= 1'b0;
      steps_q   <= 7'd0;
      tmr_q     <= 24'd0;
      pcn_q     <= 8'h00;
      tgt_q     <= 8'h00;
      step_q    <= 1'b0;
      dir_q     <= 1'b0;
      pos_done  <= 1'b0;
      pos_fault <= 1'b0;
    end else begin
      pos_done  <= 1'b0;
      pos_fault <= 1'b0;
      case (pos_q)
        P_IDLE: begin
          if (op_wake)
            pcn_q <= 8'h00; // RULE13
          if (start_pos) begin
            recal_q <= (op == `FHCC_OP_RECAL);
            tgt_q   <= pwdata[`FHCC_CMD_TGT_HI:`FHCC_CMD_TGT_LO];
            steps_q <= 7'd0;
            if (op == `FHCC_OP_RECAL)
              pcn_q <= 8'h00; // RULE6
            pos_q <= P_CHECK;
          end
        end
        P_CHECK: begin
          if (recal_q) begin
            if (tz_s) begin
              pos_done <= 1'b1; // RULE7
              pos_q    <= P_IDLE;
            end else if (steps_q == `FHCC_RECAL_MAX) begin
              pos_done  <= 1'b1; // RULE8
              pos_fault <= 1'b1; // RULE8
              pos_q     <= P_IDLE;
            end else begin
              dir_q  <= 1'b0; // RULE6
              step_q <= 1'b1;
              tmr_q  <= PULSE_CYC;
              pos_q  <= P_PULSE;
            end
          end else if (pcn_q == tgt_q) begin
            pos_done <= 1'b1; // RULE11
            pos_q    <= P_IDLE;
          end else begin
            dir_q  <= (pcn_q < tgt_q); // RULE10
            step_q <= 1'b1;
            tmr_q  <= PULSE_CYC;
            pos_q  <= P_PULSE;
          end
        end
        P_PULSE: begin
          if (tmr_q == 24'd1) begin
            step_q  <= 1'b0;
            steps_q <= steps_q + 7'd1;
            if (!recal_q)
              pcn_q <= dir_q ? pcn_q + 8'h01 : pcn_q - 8'h01; // RULE25
            // Each gap starts right after its pulse, so every gap has the same length
            tmr_q <= step_wait(srt_q); // RULE22 RULE11
            pos_q <= P_WAIT;
          end else begin
            tmr_q <= tmr_q - 24'd1;
          end
        end
        P_WAIT: begin
          if (tmr_q <= PULSE_CYC)
            pos_q <= P_CHECK;
          else
            tmr_q <= tmr_q - 24'd1;
        end
        default: pos_q <= P_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Header read
  // ****************************************************************
  wire rid_ok   = rid_q && id_valid_in;
  wire rid_fail = rid_q && !id_valid_in && idx_rise && idx_seen_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rid_q      <= 1'b0;
      idx_seen_q <= 1'b0;
      id_q       <= 32'h0000_0000;
    end else begin
      if (start_rid) begin
        rid_q      <= 1'b1;
        idx_seen_q <= 1'b0;
      end else if (rid_ok) begin
        rid_q <= 1'b0;
        id_q  <= {id_size_in, id_sect_in, id_head_in, id_cyl_in}; // RULE4
      end else if (rid_fail) begin
        rid_q <= 1'b0; // RULE5
      end else if (rid_q && idx_rise) begin
        idx_seen_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status zero, interrupt and query
  // ****************************************************************
  wire poll_fire = poll_pend_q & poll_en_q;
  wire irq_set   = pos_done | rid_ok | rid_fail | poll_fire | result_phase_in |
                   (xfer_byte_req_in & non_dma_q); // RULE14 RULE3

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_pend_q  <= 1'b1;
      irq_q        <= 1'b0;
      st0_q        <= 8'h00;
      st0_rd_q     <= 8'h00;
      noid_q       <= 1'b0;
      drive_busy_q <= 1'b0;
    end else begin
      poll_pend_q <= 1'b0;
      // A new event in the query cycle keeps the line asserted
      if (irq_set)
        irq_q <= 1'b1; // RULE14
      else if (op_sense)
        irq_q <= 1'b0; // RULE15
      if (op_wake) begin
        st0_q    <= 8'h00; // RULE13
        st0_rd_q <= 8'h00; // RULE13
        noid_q   <= 1'b0;
      end else if (pos_done) begin
        st0_q <= make_st0(pos_fault ? `FHCC_CAUSE_ABNORM : `FHCC_CAUSE_NORMAL,
                          1'b1, pos_fault); // RULE16 RULE12
      end else if (rid_fail) begin
        st0_q  <= make_st0(`FHCC_CAUSE_ABNORM, 1'b0, 1'b0); // RULE5
        noid_q <= 1'b1; // RULE5
      end else if (rid_ok) begin
        st0_q  <= make_st0(`FHCC_CAUSE_NORMAL, 1'b0, 1'b0);
        noid_q <= 1'b0;
      end else if (poll_fire) begin
        st0_q <= make_st0(`FHCC_CAUSE_POLL, 1'b0, 1'b0); // RULE24 RULE16
      end
      if (op_sense)
        st0_rd_q <= st0_q; // RULE15
      if (start_pos)
        drive_busy_q <= 1'b1;
      else if (op_sense && pos_idle)
        drive_busy_q <= 1'b0; // RULE17
    end
  end

  // ****************************************************************
  // Format preamble
  // ****************************************************************
  fhcc_fm_gen u_fm_gen (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (fmt_arm_q & idx_rise),
    .deleted  (fmt_del_q),
    .id_bytes (fmtid_q),
    .byte_q   (fmt_byte_out),
    .valid_q  (fmt_valid_out),
    .ready    (fmt_ready_in)
  );

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign step_pulse_out = step_q;
  assign step_sense_out = dir_q;
  assign ctrl_irq_out   = irq_q;

endmodule // fhcc_top

// ### rtl/fhcc_defs.vh
// Constants for the floppy head-control command block: register map, opcodes,
// status layouts and timing. Assumes a 100 MHz pclk and 8-bit APB byte addresses.
`ifndef FHCC_DEFS_VH
`define FHCC_DEFS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define FHCC_ADDR_CMD      8'h00
`define FHCC_ADDR_CFG      8'h04
`define FHCC_ADDR_STAT     8'h08
`define FHCC_ADDR_ST0      8'h0C
`define FHCC_ADDR_PCN      8'h10
`define FHCC_ADDR_ID       8'h14
`define FHCC_ADDR_ST1      8'h18
`define FHCC_ADDR_FMTID    8'h1C

// ****************************************************************
// Command opcodes, CMD[3:0]; target track in CMD[15:8]
// ****************************************************************
`define FHCC_OP_READ_ID    4'h1
`define FHCC_OP_RECAL      4'h2
`define FHCC_OP_SEEK       4'h3
`define FHCC_OP_SENSE      4'h4
`define FHCC_OP_FORMAT     4'h5
`define FHCC_OP_PDOWN      4'h6
`define FHCC_OP_WAKE       4'h7
`define FHCC_OP_XFER_ACK   4'h8
`define FHCC_CMD_OP_HI     3
`define FHCC_CMD_TGT_HI    15
`define FHCC_CMD_TGT_LO    8
`define FHCC_CMD_DEL_BIT   16

// ****************************************************************
// Configuration fields and reset values
// ****************************************************************
`define FHCC_CFG_SRT_HI    3
`define FHCC_CFG_NDMA_BIT  4
`define FHCC_CFG_POLL_BIT  5
`define FHCC_SRT_RESET     4'h0
`define FHCC_POLL_RESET    1'b1

// ****************************************************************
// Interrupt cause codes and status fields
// ****************************************************************
`define FHCC_CAUSE_NORMAL  2'b00
`define FHCC_CAUSE_ABNORM  2'b01
`define FHCC_CAUSE_POLL    2'b11
`define FHCC_ST1_NOID_BIT  0

// ****************************************************************
// Timing
// ****************************************************************
`define FHCC_CLK_MHZ       100
`define FHCC_STEP_UNIT_US  1000
`define FHCC_STEP_PULSE_NS 1000
`define FHCC_STEP_PULSE_CYC ((`FHCC_STEP_PULSE_NS * `FHCC_CLK_MHZ + 999) / 1000)
`define FHCC_SRT_SPAN      5'd16
`define FHCC_RECAL_MAX     7'd79

// ****************************************************************
// Single-density track layout
// ****************************************************************
`define FHCC_GAP4A_LEN     6'd40
`define FHCC_SYNC_LEN      6'd6
`define FHCC_GAP1_LEN      6'd26
`define FHCC_GAP2_LEN      6'd11
`define FHCC_ID_LEN        6'd4
`define FHCC_MARK_LEN      6'd1
`define FHCC_GAP_BYTE      8'hFF
`define FHCC_SYNC_BYTE     8'h00
`define FHCC_TRACK_MARK    8'hFC
`define FHCC_HEADER_MARK   8'hFE
`define FHCC_DATA_MARK     8'hFB
`define FHCC_DEL_MARK      8'hF8
`define FHCC_SEG_LAST      4'd9

`endif

// ### rtl/fhcc_fm_gen.v
// Single-density track preamble byte generator for format.
// Assumes the caller pulses start on an index edge and drains bytes via ready.
`timescale 1ns/1ps
`include "fhcc_defs.vh"

module fhcc_fm_gen (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire        deleted,
  input  wire [31:0] id_bytes,
  output reg  [7:0]  byte_q,
  output reg         valid_q,
  input  wire        ready
);

  reg  [3:0] seg_q;
  reg  [5:0] cnt_q;
  reg  [3:0] seg_d;
  reg  [5:0] cnt_d;

  function [5:0] seg_len;
    input [3:0] seg;
    begin
      case (seg)
        4'd0:    seg_len = `FHCC_GAP4A_LEN;
        4'd3:    seg_len = `FHCC_GAP1_LEN;
        4'd1,
        4'd4,
        4'd8:    seg_len = `FHCC_SYNC_LEN;
        4'd6:    seg_len = `FHCC_ID_LEN;
        4'd7:    seg_len = `FHCC_GAP2_LEN;
        default: seg_len = `FHCC_MARK_LEN;
      endcase
    end
  endfunction

  function [7:0] seg_byte;
    input [3:0]  seg;
    input [5:0]  cnt;
    input        del;
    input [31:0] id;
    begin
      case (seg)
        4'd0, 4'd3, 4'd7: seg_byte = `FHCC_GAP_BYTE;
        4'd1, 4'd4, 4'd8: seg_byte = `FHCC_SYNC_BYTE;
        4'd2:    seg_byte = `FHCC_TRACK_MARK;
        4'd5:    seg_byte = `FHCC_HEADER_MARK;
        4'd6:    seg_byte = id[cnt[1:0]*8 +: 8];
        default: seg_byte = del ? `FHCC_DEL_MARK : `FHCC_DATA_MARK;
      endcase
    end
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    seg_d = seg_q;
    cnt_d = cnt_q + 6'd1;
    if (cnt_d == seg_len(seg_q)) begin
      seg_d = seg_q + 4'd1;
      cnt_d = 6'd0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_q   <= 4'd0;
      cnt_q   <= 6'd0;
      byte_q  <= 8'h00;
      valid_q <= 1'b0;
    end else if (!valid_q) begin
      if (start) begin
        seg_q   <= 4'd0;
        cnt_q   <= 6'd0;
        byte_q  <= seg_byte(4'd0, 6'd0, deleted, id_bytes); // RULE1
        valid_q <= 1'b1;
      end
    end else if (ready) begin
      // Stalls on ready, so a slow writer never loses a gap byte
      if (seg_q == `FHCC_SEG_LAST) begin
        valid_q <= 1'b0;
      end else begin
        seg_q  <= seg_d;
        cnt_q  <= cnt_d;
        byte_q <= seg_byte(seg_d, cnt_d, deleted, id_bytes); // RULE1
      end
    end
  end

endmodule // fhcc_fm_gen

// ### tb/fhcc_top_sva.sv
// Port checker for the head-control block.
// Assumes a bind onto fhcc_top and a single pclk domain.
`timescale 1ns/1ps
`include "fhcc_defs.vh"
module fhcc_top_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        step_pulse_out,
  input wire        step_sense_out,
  input wire        ctrl_irq_out,
  input wire        id_valid_in
);
  // ********
  // Checks
  // ********
  wire sense_c;
  assign sense_c = psel && penable && pready && pwrite && paddr == `FHCC_ADDR_CMD
                   && pwdata[3:0] == `FHCC_OP_SENSE;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_err_unmapped: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access not flagged");
  a_step_width: assert property ($rose(step_pulse_out) |-> step_pulse_out[*8])
    else $error("step pulse too short");
  a_step_gap: assert property ($fell(step_pulse_out) |-> !step_pulse_out[*8])
    else $error("step pulses too close");
  a_dir_steady: assert property (step_pulse_out |=> $stable(step_sense_out))
    else $error("direction moved during step");
  a_irq_held: assert property (ctrl_irq_out && !sense_c |=> ctrl_irq_out)
    else $error("interrupt dropped without query");
  a_irq_cleared: assert property (sense_c && !id_valid_in |=> !ctrl_irq_out)
    else $error("interrupt kept after query");
  a_id_irq: assert property (id_valid_in |-> ##[1:3] ctrl_irq_out)
    else $error("no interrupt after header");
endmodule // fhcc_top_sva

bind fhcc_top fhcc_top_sva i_fhcc_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .step_pulse_out(step_pulse_out), .step_sense_out(step_sense_out),
  .ctrl_irq_out(ctrl_irq_out), .id_valid_in(id_valid_in));

// ### tb/fhcc_drive.sv
// Behavioural floppy drive: head position, track-zero sensor, index pulses.
// Assumes step pulses from the block and pclk for index timing.
`timescale 1ns/1ps
module fhcc_drive #(
  parameter START_TRK = 3
) (
  input  wire pclk,
  input  wire step_pulse_out,
  input  wire step_sense_out,
  input  wire index_run,
  input  wire tz_stuck,
  output wire track_zero_in,
  output reg  index_pulse_in = 1'b0
);
  integer trk = START_TRK;
  integer tick = 0;
  // Head cannot move below track 0
  always @(negedge step_pulse_out) begin
    if (step_sense_out)
      trk = trk + 1;
    else if (trk > 0)
      trk = trk - 1;
  end
  // Stuck sensor stands for a drive deeper than one recalibrate reaches
  assign track_zero_in = (trk == 0) && !tz_stuck;
  // Index stays low while the disk is stopped
  always @(posedge pclk) begin
    tick <= index_run ? (tick + 1) % 300 : 0;
    index_pulse_in <= index_run && tick < 4;
  end
endmodule // fhcc_drive

// ### tb/fhcc_top_bench.sv
// Self-checking bench for the head-control block over APB.
// Assumes fhcc_drive as the far side and a short step unit.
`timescale 1ns/1ps
`include "fhcc_defs.vh"
module fhcc_top_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] id_word = 32'h0;
  reg         id_valid_in = 1'b0;
  reg         index_run = 1'b0;
  reg         tz_stuck = 1'b0;
  reg         rph = 1'b0, xreq = 1'b0;
  reg  [7:0]  fmt_seen [0:127];
  wire [7:0]  fb;
  reg  [31:0] r;
  reg         e;
  wire [31:0] prdata;
  wire        pready, pslverr, tz, idx, stp, dir, irq, fv;
  integer     n_errors = 0, samples_checked = 0, cyc = 0, nsteps = 0, nfmt = 0;

  always #5 pclk = ~pclk;

  fhcc_top #(.STEP_UNIT_CYCLES(200)) i_fhcc_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .track_zero_in(tz),
    .index_pulse_in(idx), .step_pulse_out(stp), .step_sense_out(dir), .ctrl_irq_out(irq),
    .id_valid_in(id_valid_in), .id_cyl_in(id_word[7:0]), .id_head_in(id_word[15:8]),
    .id_sect_in(id_word[23:16]), .id_size_in(id_word[31:24]), .result_phase_in(rph),
    .xfer_byte_req_in(xreq), .fmt_byte_out(fb), .fmt_valid_out(fv), .fmt_ready_in(1'b1));

  fhcc_drive i_fhcc_drive (.pclk(pclk), .step_pulse_out(stp), .step_sense_out(dir),
    .index_run(index_run), .tz_stuck(tz_stuck), .track_zero_in(tz), .index_pulse_in(idx));

  always @(posedge stp) nsteps = nsteps + 1;
  always @(posedge pclk) begin
    fmt_seen[nfmt] = fb;
    nfmt = nfmt + fv;
  end
  // Longest path is the 79-step recalibrate, about 16k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end

  // ********
  // Tasks
  // ********
  task complete_run;
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task cmd(input [3:0] op, input [7:0] tgt);
    apb(1'b1, `FHCC_ADDR_CMD, {16'h0, tgt, 4'h0, op});
  endtask
  task wait_irq;
    while (irq !== 1'b1) @(posedge pclk);
  endtask
  task sense_chk(input [7:0] exp);
    cmd(`FHCC_OP_SENSE, 8'h00);
    rd_chk(`FHCC_ADDR_ST0, {24'h0, exp});
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FHCC_ADDR_STAT, 32'h0);
    check(r[2], 1'b1);
    sense_chk(8'hC0);
    apb(1'b0, `FHCC_ADDR_STAT, 32'h0);
    check(r[2], 1'b0);
    apb(1'b1, `FHCC_ADDR_CFG, 32'h3F);
    rd_chk(`FHCC_ADDR_CFG, 32'h3F);
    cmd(`FHCC_OP_RECAL, 8'h00);
    apb(1'b0, `FHCC_ADDR_STAT, 32'h0);
    check({r[6], r[0]}, 2'b10);
    wait_irq;
    sense_chk(8'h20);
    rd_chk(`FHCC_ADDR_PCN, 32'h0);
    cmd(`FHCC_OP_SEEK, 8'h02);
    wait_irq;
    sense_chk(8'h20);
    rd_chk(`FHCC_ADDR_PCN, 32'h2);
    cmd(`FHCC_OP_SEEK, 8'h01);
    wait_irq;
    sense_chk(8'h20);
    rd_chk(`FHCC_ADDR_PCN, 32'h1);
    cmd(`FHCC_OP_SEEK, 8'h03);
    wait_irq;
    // Second seek before the query must bounce
    cmd(`FHCC_OP_SEEK, 8'h00);
    apb(1'b0, `FHCC_ADDR_STAT, 32'h0);
    check(r[5], 1'b1);
    sense_chk(8'h20);
    rd_chk(`FHCC_ADDR_PCN, 32'h3);
    cmd(`FHCC_OP_READ_ID, 8'h00);
    repeat (4) @(posedge pclk);
    id_word <= 32'h02070103;
    id_valid_in <= 1'b1;
    @(posedge pclk);
    id_valid_in <= 1'b0;
    wait_irq;
    sense_chk(8'h00);
    rd_chk(`FHCC_ADDR_ID, 32'h02070103);
    index_run <= 1'b1;
    cmd(`FHCC_OP_READ_ID, 8'h00);
    wait_irq;
    sense_chk(8'h40);
    rd_chk(`FHCC_ADDR_ST1, 32'h1);
    index_run <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    check(e, 1'b1);
    cmd(`FHCC_OP_PDOWN, 8'h00);
    cmd(`FHCC_OP_WAKE, 8'h00);
    rd_chk(`FHCC_ADDR_PCN, 32'h0);
    rd_chk(`FHCC_ADDR_ST0, 32'h0);
    rph <= 1'b1;
    @(posedge pclk);
    rph <= 1'b0;
    rd_chk(`FHCC_ADDR_STAT, 32'h4);
    xreq <= 1'b1;
    @(posedge pclk);
    xreq <= 1'b0;
    rd_chk(`FHCC_ADDR_STAT, 32'hC);
    cmd(`FHCC_OP_XFER_ACK, 8'h00);
    sense_chk(8'h00);
    rd_chk(`FHCC_ADDR_STAT, 32'h0);
    apb(1'b1, `FHCC_ADDR_FMTID, 32'h0205_0103);
    apb(1'b1, `FHCC_ADDR_CMD, 32'h0001_0005);
    index_run <= 1'b1;
    while (nfmt < 102) @(posedge pclk);
    check({fmt_seen[46], fmt_seen[79], fmt_seen[80], fmt_seen[101]}, 32'hFCFE03F8);
    tz_stuck <= 1'b1;
    nsteps = 0;
    cmd(`FHCC_OP_RECAL, 8'h00);
    wait_irq;
    sense_chk(8'h70);
    check(nsteps, 79);
    check(nfmt, 102);
    complete_run;
  end
endmodule // fhcc_top_bench
